// ### rtl/imbx_map.svh
// register offsets, field positions and sizes of the inter-core mailbox
`ifndef IMBX_MAP_SVH
`define IMBX_MAP_SVH

`define IMBX_ADDR_W        12
`define IMBX_STATUS_OFS    12'h050
`define IMBX_TX_PORT_OFS   12'h054
`define IMBX_RX_PORT_OFS   12'h058
`define IMBX_IRQ_MASK_OFS  12'h100

`define IMBX_DATA_W        32
`define IMBX_DEPTH         4'h8
`define IMBX_PTR_W         3
`define IMBX_CNT_W         4

`define IMBX_BIT_RX_HAS    0
`define IMBX_BIT_TX_ROOM   1
`define IMBX_BIT_TX_OVF    2
`define IMBX_BIT_RX_UNF    3
`define IMBX_FLAG_W        4

`define IMBX_MASK_RESET    4'hD
`define IMBX_PTR_ONE       3'h1
`define IMBX_CNT_ONE       4'h1
`define IMBX_FULL_STRB     4'hF
`define IMBX_RESP_OKAY     2'h0
`define IMBX_RESP_SLVERR   2'h2
`define IMBX_ZERO_WORD     32'h00000000

`endif

// ### rtl/imbx_pkg.sv
// types shared by the inter-core mailbox files
package imbx_pkg;
	// read channel sequencing
	typedef enum logic [1:0] {
		RD_IDLE,
		RD_FETCH,
		RD_LOAD,
		RD_RESP
	} imbx_rd_state_t;
endpackage

// ### rtl/imbx_fifo_mem.sv
// eight-word storage of one mailbox direction, registered read
`timescale 1ns/1ps
`include "imbx_map.svh"

module imbx_fifo_mem (
	input  wire logic                      aclk,    // system clock
	input  wire logic                      aresetn, // sync reset, low
	input  wire logic                      we,      // write strobe
	input  wire logic [`IMBX_PTR_W-1:0]    waddr,   // write slot
	input  wire logic [`IMBX_DATA_W-1:0]   wdata,   // word to store
	input  wire logic [`IMBX_PTR_W-1:0]    raddr,   // read slot
	output logic      [`IMBX_DATA_W-1:0]   rdata    // registered word
);
	logic [`IMBX_DATA_W-1:0] mem [0:`IMBX_DEPTH-1]; // storage array

	// write port
	always_ff @(posedge aclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// read port, one cycle latency
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata <= `IMBX_ZERO_WORD;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule

// ### rtl/imbx_top.sv
// two-direction inter-core mailbox with AXI4-Lite register access
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "imbx_map.svh"

//Contract
//RULE1 - two independent 32-bit, 8-deep FIFOs
//RULE2 - core 0: rx from fifo1, tx fifo0
//RULE3 - core 1: rx from fifo0, tx fifo1
//RULE4 - irq is OR of rx-has, ovf, unf
//RULE5 - empty read ignored, underflow sticky bit 3
//RULE6 - full write dropped, overflow sticky bit 2
//RULE7 - bit 1 reads tx FIFO has room
//RULE8 - bit 0 reads rx FIFO not empty
//RULE9 - write 0x054 pushes into tx FIFO (code pushes only when all four byte enables are set)
//RULE10 - read 0x058 pops rx FIFO word
//RULE11 - status 0x050, own flags, upper zero
//RULE12 - core id per access, FIFO order
//RULE13 - cores check flags before access
module imbx_top (
	input  wire logic                     aclk,          // 25 MHz system clock
	input  wire logic                     aresetn,       // sync reset, low
	input  wire logic [`IMBX_ADDR_W-1:0]  s_axi_awaddr,  // write address
	input  wire logic                     s_axi_awcore,  // writing core id
	input  wire logic                     s_axi_awvalid, // write address valid
	output logic                          s_axi_awready, // write address ready
	input  wire logic [`IMBX_DATA_W-1:0]  s_axi_wdata,   // write data
	input  wire logic [3:0]               s_axi_wstrb,   // write byte enables
	input  wire logic                     s_axi_wvalid,  // write data valid
	output logic                          s_axi_wready,  // write data ready
	output logic [1:0]                    s_axi_bresp,   // write response
	output logic                          s_axi_bvalid,  // write response valid
	input  wire logic                     s_axi_bready,  // write response ready
	input  wire logic [`IMBX_ADDR_W-1:0]  s_axi_araddr,  // read address
	input  wire logic                     s_axi_arcore,  // reading core id
	input  wire logic                     s_axi_arvalid, // read address valid
	output logic                          s_axi_arready, // read address ready
	output logic [`IMBX_DATA_W-1:0]       s_axi_rdata,   // read data
	output logic [1:0]                    s_axi_rresp,   // read response
	output logic                          s_axi_rvalid,  // read data valid
	input  wire logic                     s_axi_rready,  // read data ready
	output logic [1:0]                    irq            // per-core interrupt
);
	// fifo index f carries words from core f to the other core
	logic [`IMBX_CNT_W-1:0]  count  [0:1];    // words held
	logic [`IMBX_PTR_W-1:0]  wr_ptr [0:1];    // next slot to fill
	logic [`IMBX_PTR_W-1:0]  rd_ptr [0:1];    // oldest word
	logic [`IMBX_DATA_W-1:0] mem_q  [0:1];    // registered head word
	logic [1:0]              push;            // push strobe per fifo
	logic [1:0]              pop;             // pop strobe per fifo
	logic [1:0]              tx_overflow_sticky;  // per core
	logic [1:0]              rx_underflow_sticky; // per core
	logic [1:0]              set_ovf;         // overflow events
	logic [1:0]              set_unf;         // underflow events
	logic [1:0]              clr_ovf;         // software clears
	logic [1:0]              clr_unf;         // software clears
	logic [`IMBX_FLAG_W-1:0] irq_mask [0:1];  // per-core interrupt mask

	// write channel holding registers
	logic [`IMBX_ADDR_W-1:0] aw_addr;         // latched write address
	logic                    aw_core;         // latched writing core
	logic [`IMBX_DATA_W-1:0] w_data;          // latched write data
	logic [3:0]              w_strb;          // latched byte enables
	logic                    wr_exec;         // both halves held, act now

	// read channel holding registers
	imbx_pkg::imbx_rd_state_t rd_state;       // read sequencer
	logic [`IMBX_ADDR_W-1:0]  ar_addr;        // latched read address
	logic                     ar_core;        // latched reading core

	// receive fifo of a core is the one the other core fills
	function automatic logic rx_fifo(input logic core);
		rx_fifo = ~core;
	endfunction

	// tx fifo of a core is its own index
	function automatic logic tx_fifo(input logic core);
		tx_fifo = core;
	endfunction

	// status word as seen by one core
	function automatic logic [`IMBX_FLAG_W-1:0] flags_of(input logic core);
		logic [`IMBX_FLAG_W-1:0] f;
		f = '0;
		f[`IMBX_BIT_RX_HAS]  = (count[rx_fifo(core)] != '0);
		f[`IMBX_BIT_TX_ROOM] = (count[tx_fifo(core)] != `IMBX_DEPTH);
		f[`IMBX_BIT_TX_OVF]  = tx_overflow_sticky[core];
		f[`IMBX_BIT_RX_UNF]  = rx_underflow_sticky[core];
		flags_of = f;
	endfunction

	// storage, one per direction
	// RULE1 two fifos
	for (genvar g = 0; g < 2; g++) begin : g_mem
		imbx_fifo_mem u_mem (
			.aclk    (aclk),
			.aresetn (aresetn),
			.we      (push[g]),
			.waddr   (wr_ptr[g]),
			.wdata   (w_data),
			.raddr   (rd_ptr[g]),
			.rdata   (mem_q[g])
		);
	end

	assign wr_exec = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	// push and overflow decode from the held write
	always_comb begin
		push    = '0;
		set_ovf = '0;
		clr_ovf = '0;
		clr_unf = '0;
		if (wr_exec) begin
			if (aw_addr == `IMBX_TX_PORT_OFS) begin
				if (w_strb == `IMBX_FULL_STRB) begin
					// RULE6 full write dropped
					if (count[tx_fifo(aw_core)] == `IMBX_DEPTH) begin
						set_ovf[aw_core] = 1'b1;
					end else begin
						// RULE9 push to tx
						push[tx_fifo(aw_core)] = 1'b1;
					end
				end
			end else if (aw_addr == `IMBX_STATUS_OFS) begin
				if (w_strb[0]) begin
					clr_ovf[aw_core] = w_data[`IMBX_BIT_TX_OVF];
					clr_unf[aw_core] = w_data[`IMBX_BIT_RX_UNF];
				end
			end
		end
	end

	// pop and underflow decode from the read sequencer
	always_comb begin
		pop     = '0;
		set_unf = '0;
		if (rd_state == imbx_pkg::RD_LOAD && ar_addr == `IMBX_RX_PORT_OFS) begin
			// RULE5 empty read ignored
			if (count[rx_fifo(ar_core)] == '0) begin
				set_unf[ar_core] = 1'b1;
			end else begin
				// RULE10 pop rx
				pop[rx_fifo(ar_core)] = 1'b1;
			end
		end
	end

	// fifo pointers and fill counts
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 2; i++) begin
				count[i]  <= '0;
				wr_ptr[i] <= '0;
				rd_ptr[i] <= '0;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				// RULE12 first in first out
				if (push[i]) begin
					wr_ptr[i] <= wr_ptr[i] + `IMBX_PTR_ONE;
				end
				if (pop[i]) begin
					rd_ptr[i] <= rd_ptr[i] + `IMBX_PTR_ONE;
				end
				if (push[i] && !pop[i]) begin
					count[i] <= count[i] + `IMBX_CNT_ONE;
				end else if (pop[i] && !push[i]) begin
					count[i] <= count[i] - `IMBX_CNT_ONE;
				end
			end
		end
	end

	// sticky error flags, an event beats a same-cycle clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_overflow_sticky  <= '0;
			rx_underflow_sticky <= '0;
		end else begin
			// RULE6 overflow sticky
			tx_overflow_sticky  <= (tx_overflow_sticky & ~clr_ovf) | set_ovf;
			// RULE5 underflow sticky
			rx_underflow_sticky <= (rx_underflow_sticky & ~clr_unf) | set_unf;
		end
	end

	// interrupt mask registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask[0] <= `IMBX_MASK_RESET;
			irq_mask[1] <= `IMBX_MASK_RESET;
		end else if (wr_exec && aw_addr == `IMBX_IRQ_MASK_OFS && w_strb[0]) begin
			irq_mask[aw_core] <= w_data[`IMBX_FLAG_W-1:0];
		end
	end

	// per-core interrupt, one cycle behind the flags
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= '0;
		end else begin
			// RULE4 irq or of flags
			irq[0] <= |(flags_of(1'b0) & irq_mask[0]);
			irq[1] <= |(flags_of(1'b1) & irq_mask[1]);
		end
	end

	// write address channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			aw_addr       <= '0;
			aw_core       <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			// RULE12 capture core id
			s_axi_awready <= 1'b0;
			aw_addr       <= s_axi_awaddr;
			aw_core       <= s_axi_awcore;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	// write data channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b1;
			w_data       <= '0;
			w_strb       <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			w_data       <= s_axi_wdata;
			w_strb       <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	// write response, error for unmapped offsets
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `IMBX_RESP_OKAY;
		end else if (wr_exec) begin
			s_axi_bvalid <= 1'b1;
			if (aw_addr == `IMBX_TX_PORT_OFS || aw_addr == `IMBX_STATUS_OFS ||
			    aw_addr == `IMBX_IRQ_MASK_OFS) begin
				s_axi_bresp <= `IMBX_RESP_OKAY;
			end else begin
				s_axi_bresp <= `IMBX_RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read sequencer: take, let head word settle, answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state      <= imbx_pkg::RD_IDLE;
			s_axi_arready <= 1'b1;
			ar_addr       <= '0;
			ar_core       <= 1'b0;
		end else begin
			case (rd_state)
				imbx_pkg::RD_IDLE: begin
					if (s_axi_arvalid) begin
						s_axi_arready <= 1'b0;
						ar_addr       <= s_axi_araddr;
						ar_core       <= s_axi_arcore;
						rd_state      <= imbx_pkg::RD_FETCH;
					end
				end
				imbx_pkg::RD_FETCH: begin
					rd_state <= imbx_pkg::RD_LOAD;
				end
				imbx_pkg::RD_LOAD: begin
					rd_state <= imbx_pkg::RD_RESP;
				end
				default: begin
					if (s_axi_rready) begin
						s_axi_arready <= 1'b1;
						rd_state      <= imbx_pkg::RD_IDLE;
					end
				end
			endcase
		end
	end

	// read data and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= `IMBX_RESP_OKAY;
		end else if (rd_state == imbx_pkg::RD_LOAD) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `IMBX_RESP_OKAY;
			s_axi_rdata  <= '0;
			if (ar_addr == `IMBX_STATUS_OFS) begin
				// RULE11 own flags only
				// RULE7 tx room flag
				// RULE8 rx has word
				s_axi_rdata[`IMBX_FLAG_W-1:0] <= flags_of(ar_core);
			end else if (ar_addr == `IMBX_RX_PORT_OFS) begin
				// RULE2 core 0 view
				// RULE3 core 1 view
				if (count[rx_fifo(ar_core)] != '0) begin
					s_axi_rdata <= mem_q[rx_fifo(ar_core)];
				end
			end else if (ar_addr == `IMBX_IRQ_MASK_OFS) begin
				s_axi_rdata[`IMBX_FLAG_W-1:0] <= irq_mask[ar_core];
			end else if (ar_addr != `IMBX_TX_PORT_OFS) begin
				s_axi_rresp <= `IMBX_RESP_SLVERR;
			end
		end else if (rd_state == imbx_pkg::RD_RESP && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// ### tb/imbx_monitor.sv
// port-level checks of the mailbox bus and flags
`timescale 1ns/1ps
`include "imbx_map.svh"
module imbx_monitor (
	input wire logic        aclk,          // clock
	input wire logic        aresetn,       // reset, low
	input wire logic        s_axi_awvalid, // aw valid
	input wire logic        s_axi_awready, // aw ready
	input wire logic        s_axi_wvalid,  // w valid
	input wire logic        s_axi_wready,  // w ready
	input wire logic        s_axi_bvalid,  // b valid
	input wire logic        s_axi_bready,  // b ready
	input wire logic [11:0] s_axi_araddr,  // read address
	input wire logic        s_axi_arvalid, // ar valid
	input wire logic        s_axi_arready, // ar ready
	input wire logic [31:0] s_axi_rdata,   // read data
	input wire logic [1:0]  s_axi_rresp,   // read response
	input wire logic        s_axi_rvalid,  // r valid
	input wire logic        s_axi_rready,  // r ready
	input wire logic [1:0]  irq            // interrupts
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// read address accepted
	sequence ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// status read accepted
	sequence st_take;
		ar_take ##0 (s_axi_araddr == `IMBX_STATUS_OFS);
	endsequence
	ar_rvalid_a: assert property (ar_take |-> ##[2:4] s_axi_rvalid)
		else $error("read answer late");
	aw_bvalid_a: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
		|-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	// bvalid stands until the edge with bready, then falls
	b_hold_a: assert property (s_axi_bvalid |=>
		($past(s_axi_bready) ? !s_axi_bvalid : s_axi_bvalid))
		else $error("bvalid not held to handshake");
	// rvalid and rdata stand until the edge with rready, then rvalid falls
	r_hold_a: assert property (s_axi_rvalid |=>
		($past(s_axi_rready) ? !s_axi_rvalid : (s_axi_rvalid && $stable(s_axi_rdata))))
		else $error("read data unstable");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	st_fields_a: assert property (st_take |->
		##[2:4] (s_axi_rvalid && s_axi_rdata[31:4] == 28'h0))
		else $error("status upper bits set");
	unmap_err_a: assert property ((ar_take ##0 s_axi_araddr == 12'h0FC)
		|-> ##[2:4] (s_axi_rvalid && s_axi_rresp == 2'h2))
		else $error("unmapped read not refused");
	reset_idle_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && irq == 2'h0)
		else $error("outputs busy after reset");
endmodule
bind imbx_top imbx_monitor imbx_monitor_inst (.*);

// ### tb/imbx_core_model.sv
// two cores sharing one bus master port
`timescale 1ns/1ps
module imbx_core_model (
	input  wire logic        aclk,          // clock
	input  wire logic        s_axi_awready, // aw ready
	input  wire logic        s_axi_wready,  // w ready
	input  wire logic        s_axi_bvalid,  // b valid
	input  wire logic [1:0]  s_axi_bresp,   // b response
	input  wire logic        s_axi_arready, // ar ready
	input  wire logic        s_axi_rvalid,  // r valid
	input  wire logic [31:0] s_axi_rdata,   // r data
	input  wire logic [1:0]  s_axi_rresp,   // r response
	output logic      [11:0] s_axi_awaddr,  // write address
	output logic             s_axi_awcore,  // writing core
	output logic             s_axi_awvalid, // aw valid
	output logic      [31:0] s_axi_wdata,   // write data
	output logic      [3:0]  s_axi_wstrb,   // byte enables
	output logic             s_axi_wvalid,  // w valid
	output logic             s_axi_bready,  // b ready
	output logic      [11:0] s_axi_araddr,  // read address
	output logic             s_axi_arcore,  // reading core
	output logic             s_axi_arvalid, // ar valid
	output logic             s_axi_rready   // r ready
);
	logic to = 1'b0;        // a wait ran out
	logic [3:0] strb = 4'hF; // byte enables of the next write
	initial begin
		{s_axi_awaddr, s_axi_awcore, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arcore} = '0;
		{s_axi_arvalid, s_axi_rready} = '0;
	end
	// one write, core id with address
	task automatic wr(input logic c, input logic [11:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		logic done;
		done = 1'b0;
		r = 2'h3;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awcore <= c;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= strb;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 40 && !done; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) to = 1'b1;
	endtask
	// one read, core id with address
	task automatic rd(input logic c, input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		logic done;
		done = 1'b0;
		{r, d} = '1;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arcore <= c;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 40 && !done; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done) to = 1'b1;
	endtask
endmodule

// ### tb/intercore_mailbox_fifo_tb.sv
// self-checking bench of the two-way mailbox
`timescale 1ns/1ps
module intercore_mailbox_fifo_tb;
	logic aclk, aresetn, s_axi_awcore, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arcore, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, irq;
	int failures = 0;   // mismatches
	int n_compared = 0; // comparisons
	imbx_top imbx_top_inst (.*);
	imbx_core_model imbx_core_model_inst (.*);
	// 25 MHz clock
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	task automatic print_verdict;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic c, input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
		logic [1:0] r;
		imbx_core_model_inst.wr(c, a, d, r);
		if (imbx_core_model_inst.to) begin
			failures++;
			print_verdict;
		end else begin
			chk({32'h0, r}, {32'h0, e});
		end
	endtask
	task automatic rd(input logic c, input logic [11:0] a, input logic [31:0] ed, input logic [1:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		imbx_core_model_inst.rd(c, a, d, r);
		if (imbx_core_model_inst.to) begin
			failures++;
			print_verdict;
		end else begin
			chk({r, d}, {e, ed});
		end
	endtask
	task automatic irqk(input logic [1:0] e);
		repeat (3) @(posedge aclk);
		chk({32'h0, irq}, {32'h0, e});
	endtask
	task automatic t_fill;
		for (int i = 0; i < 8; i++) wr(0, 12'h054, 32'hA5000000 + i, 2'h0);
		rd(0, 12'h050, 32'h0, 2'h0);
		rd(1, 12'h050, 32'h3, 2'h0);
		irqk(2'h2);
		wr(0, 12'h054, 32'hDEAD0000, 2'h0);
		rd(0, 12'h050, 32'h4, 2'h0);
		irqk(2'h3);
		wr(0, 12'h050, 32'h4, 2'h0);
		rd(0, 12'h050, 32'h0, 2'h0);
		$display("done fill");
	endtask
	task automatic t_drain;
		for (int i = 0; i < 8; i++) rd(1, 12'h058, 32'hA5000000 + i, 2'h0);
		rd(1, 12'h058, 32'h0, 2'h0);
		rd(1, 12'h050, 32'hA, 2'h0);
		wr(1, 12'h050, 32'h8, 2'h0);
		rd(1, 12'h050, 32'h2, 2'h0);
		irqk(2'h0);
		$display("done drain");
	endtask
	task automatic t_rev;
		wr(1, 12'h054, 32'hC0DE1234, 2'h0);
		rd(0, 12'h050, 32'h3, 2'h0);
		rd(0, 12'h058, 32'hC0DE1234, 2'h0);
		rd(1, 12'h050, 32'h2, 2'h0);
		$display("done reverse");
	endtask
	task automatic t_mask;
		wr(1, 12'h100, 32'h0, 2'h0);
		rd(1, 12'h058, 32'h0, 2'h0);
		irqk(2'h0);
		rd(1, 12'h100, 32'h0, 2'h0);
		wr(1, 12'h100, 32'hD, 2'h0);
		irqk(2'h2);
		wr(1, 12'h050, 32'h8, 2'h0);
		irqk(2'h0);
		$display("done mask");
	endtask
	task automatic t_unmap;
		rd(0, 12'h0FC, 32'h0, 2'h2);
		wr(0, 12'h0FC, 32'h1, 2'h2);
		wr(0, 12'h058, 32'h1, 2'h2);
		rd(0, 12'h054, 32'h0, 2'h0);
		// partial-strobe word must not enter the tx fifo
		imbx_core_model_inst.strb = 4'h3;
		wr(0, 12'h054, 32'h1, 2'h0);
		imbx_core_model_inst.strb = 4'hF;
		rd(1, 12'h050, 32'h2, 2'h0);
		$display("done unmapped");
	endtask
	// reset, then the scenarios
	initial begin
		aresetn = 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(0, 12'h050, 32'h2, 2'h0);
		rd(1, 12'h050, 32'h2, 2'h0);
		$display("done reset");
		t_fill;
		t_drain;
		t_rev;
		t_mask;
		t_unmap;
		print_verdict;
	end
endmodule
